// file: core/wdr_watchdog.sv
// Purpose: Watchdog control register, reset-cause flags and modes.
// Assumes: CPU accesses are single-cycle strobes on clk; rst is the
//          power-on reset; ext and brown-out events are one-cycle pulses.
// Notes:   Read data appear in the cycle after the read strobe.
//
// Overview of operation
// R1 - Watchdog reset sets flag bit 3
// R2 - Brown-out reset sets flag bit 2
// R3 - External reset sets flag bit 1
// R4 - Power-on sets bit 0; only software clears
// R5 - Cause register at 0x54, I/O at 0x34
// R6 - Timeout in interrupt mode sets interrupt flag
// R7 - Vector or written one clears interrupt flag
// R8 - Interrupt needs flag, enable and global enable
// R9 - Enables select stopped, interrupt, reset, combined
// R10 - Programmed always-on fuse forces reset mode
// R11 - Vector clears enable and flag in combined
// R12 - Unserviced combined interrupt then timeout resets
// R13 - Software re-enables interrupt outside service routine
// R14 - Reset-enable clear, prescaler change need change-enable
// R15 - Change enable self-clears after four cycles
// R16 - Watchdog cause flag forces reset enable
// R17 - Timeout is 2048 times two to code
// R18 - Control register layout at offset 0x60
// R19 - Software reads and clears causes early
// R20 - Timed sequence: arm, then write within four
// R21 - Counter counts dedicated 128 kHz oscillator
// R22 - Restart instruction zeroes the counter
// R23 - Watchdog reset pulse lasts one cycle
// R24 - Crossing events are seen exactly once
`timescale 1ns/10ps
`default_nettype none

module wdr_watchdog #(
	parameter int TIMEOUT_BASE = wdr_pkg::WDR_TIMEOUT_BASE
) (
	// Clock and power-on reset
	input  wire logic       clk,
	input  wire logic       rst,
	// CPU register access
	input  wire logic [7:0] bus_addr,
	input  wire logic       bus_io_space,
	input  wire logic       bus_wr_en,
	input  wire logic       bus_rd_en,
	input  wire logic [7:0] bus_wdata,
	output logic      [7:0] bus_rdata,
	// CPU core signals
	input  wire logic       global_int_en,
	input  wire logic       vector_ack,
	input  wire logic       wdt_restart,
	output logic            irq_req,
	// Reset sources and fuse
	input  wire logic       ext_reset_evt,
	input  wire logic       brownout_evt,
	input  wire logic       always_on_fuse,
	input  wire logic       osc_level,
	output logic            sys_reset_pulse
);
	import wdr_pkg::*;

	typedef struct packed {
		logic [3:0] rcause;
		logic       int_flag;
		logic       int_en;
		logic       rst_en;
		logic [3:0] ps_code;
		logic [2:0] ce_cnt;
		logic       rst_pulse;
		logic [7:0] rdata;
	} wdr_state_t;

	localparam wdr_state_t WDR_STATE_RST = '{
		rcause:    WDR_RCAUSE_POR,
		int_flag:  WDR_WCTRL_RST[WDR_WC_IF],
		int_en:    WDR_WCTRL_RST[WDR_WC_IE],
		rst_en:    WDR_WCTRL_RST[WDR_WC_RE],
		ps_code:   {WDR_WCTRL_RST[WDR_WC_P3], WDR_WCTRL_RST[WDR_WC_PMSB:0]},
		ce_cnt:    3'h0,
		rst_pulse: 1'b0,
		rdata:     8'h00
	};

	wdr_state_t s_q;
	wdr_state_t s_d;
	logic       fuse_prog;
	logic       wde_eff;
	logic       timeout_interrupt_enable_eff;
	logic       running;
	logic       ce_open;
	logic       sel_rc;
	logic       sel_wc;
	logic       wc_wr;
	logic       rc_wr;
	logic       timeout;
	logic       tmo_irq;
	logic       tmo_rst;
	logic       sys_evt;

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	// The fuse reads 0 when programmed and then locks reset mode. [R10]
	assign fuse_prog = ~always_on_fuse;
	// A pending watchdog cause keeps reset enable on. [R16]
	assign wde_eff   = s_q.rst_en | s_q.rcause[WDR_RC_WDOG] | fuse_prog;
	assign timeout_interrupt_enable_eff  = s_q.int_en & ~fuse_prog; // [R10]
	assign running   = wde_eff | timeout_interrupt_enable_eff; // [R9]
	assign ce_open   = (s_q.ce_cnt != 3'h0);

	// Combined mode fires the interrupt first, then resets if the
	// flag is still pending at the next timeout. [R9] [R12]
	assign tmo_irq = timeout & timeout_interrupt_enable_eff & ~(wde_eff & s_q.int_flag);
	assign tmo_rst = timeout & wde_eff & (~timeout_interrupt_enable_eff | s_q.int_flag);
	assign sys_evt = tmo_rst | ext_reset_evt | brownout_evt;

	// ----------------------------------------------------------------
	// Address decode
	// ----------------------------------------------------------------
	// The control register lies above the I/O window, so only the
	// data-space path reaches it. [R5] [R18]
	assign sel_rc = bus_io_space ? (bus_addr == WDR_RCAUSE_IO)
	                             : (bus_addr == WDR_RCAUSE_OFS);
	assign sel_wc = ~bus_io_space & (bus_addr == WDR_WCTRL_OFS);
	assign wc_wr  = bus_wr_en & sel_wc;
	assign rc_wr  = bus_wr_en & sel_rc;

	// ----------------------------------------------------------------
	// Timeout counter
	// ----------------------------------------------------------------
	wdr_counter #(
		.TIMEOUT_BASE(TIMEOUT_BASE)
	) u_counter (
		.clk      (clk),
		.rst      (rst),
		.osc_level(osc_level),
		.run      (running),
		.restart  (wdt_restart | sys_evt), // [R22]
		.code     (s_q.ps_code),
		.timeout  (timeout)
	);

	// ----------------------------------------------------------------
	// Next state
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.rst_pulse = 1'b0;
		s_d.rdata = 8'h00;

		// Change-enable window counts down when not rewritten. [R15]
		if (ce_open) begin
			s_d.ce_cnt = s_q.ce_cnt - 3'h1;
		end

		if (wc_wr) begin
			if (bus_wdata[WDR_WC_IF]) begin
				s_d.int_flag = 1'b0; // [R7]
			end
			s_d.int_en = bus_wdata[WDR_WC_IE];
			// Setting reset enable is always allowed; clearing is
			// guarded by the window and by the cause flag. [R14] [R16]
			if (bus_wdata[WDR_WC_RE]) begin
				s_d.rst_en = 1'b1;
			end else if (ce_open && !s_q.rcause[WDR_RC_WDOG]) begin
				s_d.rst_en = 1'b0;
			end
			if (ce_open) begin
				s_d.ps_code = {bus_wdata[WDR_WC_P3],
				               bus_wdata[WDR_WC_PMSB:0]}; // [R14]
			end
			// A write with change enable clear consumes the window.
			if (bus_wdata[WDR_WC_CE]) begin
				s_d.ce_cnt = WDR_CE_HOLD; // [R15]
			end else begin
				s_d.ce_cnt = 3'h0;
			end
		end

		if (vector_ack) begin
			s_d.int_flag = 1'b0; // [R7]
			// Leaving combined mode keeps the reset as a safety net.
			if (wde_eff) begin
				s_d.int_en = 1'b0; // [R11]
			end
		end

		// Software only clears cause flags; a one leaves them. [R4]
		if (rc_wr) begin
			s_d.rcause = s_q.rcause & bus_wdata[WDR_RC_MSB:0];
		end

		// Hardware sets win over software and vector clears in the same cycle.
		if (tmo_irq) begin
			s_d.int_flag = 1'b1; // [R6]
		end

		// Any system reset returns the control register to reset.
		if (sys_evt) begin
			s_d.int_flag = WDR_STATE_RST.int_flag;
			s_d.int_en = WDR_STATE_RST.int_en;
			s_d.rst_en = WDR_STATE_RST.rst_en;
			s_d.ps_code = WDR_STATE_RST.ps_code;
			s_d.ce_cnt = WDR_STATE_RST.ce_cnt;
		end
		if (tmo_rst) begin
			s_d.rcause[WDR_RC_WDOG] = 1'b1; // [R1]
			s_d.rst_pulse = 1'b1; // [R23]
		end
		if (brownout_evt) begin
			s_d.rcause[WDR_RC_BOUT] = 1'b1; // [R2]
		end
		if (ext_reset_evt) begin
			s_d.rcause[WDR_RC_EXTF] = 1'b1; // [R3]
		end

		// Reads return the state before this cycle's updates.
		if (bus_rd_en && sel_rc) begin
			s_d.rdata = {4'h0, s_q.rcause}; // [R5]
		end else if (bus_rd_en && sel_wc) begin
			s_d.rdata = {s_q.int_flag, timeout_interrupt_enable_eff, s_q.ps_code[3], ce_open,
			             wde_eff, s_q.ps_code[WDR_WC_PMSB:0]}; // [R18]
		end
	end

	// Power-on clears the other cause flags and sets power-on. [R1] [R4]
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= WDR_STATE_RST;
		end else begin
			s_q <= s_d;
		end
	end

	// ----------------------------------------------------------------
	// Outputs
	// ----------------------------------------------------------------
	assign bus_rdata       = s_q.rdata;
	assign sys_reset_pulse = s_q.rst_pulse;
	assign irq_req         = s_q.int_flag & timeout_interrupt_enable_eff & global_int_en; // [R8]

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking wdr_cb @(posedge clk);
	endclocking
	default disable iff (rst);

	wdog_set_a: assert property (tmo_rst |=> s_q.rcause[WDR_RC_WDOG]) // [R1]
		else $error("watchdog cause flag not set");

	bout_set_a: assert property (brownout_evt |=> s_q.rcause[WDR_RC_BOUT]) // [R2]
		else $error("brown-out cause flag not set");

	external_reset_cause_flag_set_a: assert property (ext_reset_evt |=> s_q.rcause[WDR_RC_EXTF]) // [R3]
		else $error("external cause flag not set");

	pwon_hold_a: assert property (s_q.rcause[WDR_RC_PWON] // [R4]
		&& !(rc_wr && !bus_wdata[WDR_RC_PWON])
		|=> s_q.rcause[WDR_RC_PWON])
		else $error("power-on flag lost without a write");

	rc_read_a: assert property (bus_rd_en && sel_rc // [R5]
		|=> bus_rdata == {4'h0, $past(s_q.rcause)})
		else $error("cause register read mismatch");

	flag_set_a: assert property (tmo_irq && !sys_evt |=> s_q.int_flag) // [R6]
		else $error("interrupt flag not set on timeout");

	vec_clear_a: assert property (vector_ack && !tmo_irq // [R7]
		|=> !s_q.int_flag)
		else $error("interrupt flag not cleared by vector");

	irq_gate_a: assert property (irq_req // [R8]
		|-> s_q.int_flag && s_q.int_en && global_int_en && always_on_fuse)
		else $error("interrupt requested without all enables");

	fuse_reset_a: assert property (!always_on_fuse && timeout // [R10]
		|=> sys_reset_pulse)
		else $error("programmed fuse did not force reset");

	comb_reset_a: assert property (timeout && timeout_interrupt_enable_eff && wde_eff // [R12]
		&& s_q.int_flag |=> sys_reset_pulse && s_q.rcause[WDR_RC_WDOG])
		else $error("unserviced combined timeout did not reset");

	wde_guard_a: assert property (wc_wr && !ce_open && !sys_evt // [R14]
		&& s_q.rst_en |=> s_q.rst_en)
		else $error("reset enable cleared outside window");

	ce_window_a: assert property (wc_wr && bus_wdata[WDR_WC_CE] // [R15]
		##1 !wc_wr [*4] |=> !ce_open)
		else $error("change enable not cleared after four cycles");

	wde_force_a: assert property (s_q.rcause[WDR_RC_WDOG] // [R16]
		&& bus_rd_en && sel_wc |=> bus_rdata[WDR_WC_RE])
		else $error("reset enable not forced by cause flag");

	pulse_one_a: assert property (sys_reset_pulse |=> !sys_reset_pulse) // [R23]
		else $error("reset pulse longer than one cycle");

	irq_then_ack_c: cover property (tmo_irq && wde_eff ##[1:20] vector_ack);
	reset_pulse_c: cover property (sys_reset_pulse);
	timed_seq_c: cover property (wc_wr && bus_wdata[WDR_WC_CE]
		##[1:4] wc_wr && !bus_wdata[WDR_WC_CE]);

endmodule

`default_nettype wire

// file: core/wdr_pkg.sv
// Purpose: Shared constants for the watchdog and reset-cause block.
// Assumes: Eight-bit CPU register access, one system clock.
// Notes:   Register offsets are data-space byte addresses.
package wdr_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam logic [7:0] WDR_RCAUSE_OFS = 8'h54;
	localparam logic [7:0] WDR_IO_BASE    = 8'h20;
	localparam logic [7:0] WDR_RCAUSE_IO  = WDR_RCAUSE_OFS - WDR_IO_BASE;
	localparam logic [7:0] WDR_WCTRL_OFS  = 8'h60;
	localparam logic [7:0] WDR_WCTRL_RST  = 8'h00;
	localparam logic [3:0] WDR_RCAUSE_POR = 4'h1;

	// ----------------------------------------------------------------
	// Reset-cause register fields
	// ----------------------------------------------------------------
	localparam int WDR_RC_WDOG = 3;
	localparam int WDR_RC_BOUT = 2;
	localparam int WDR_RC_EXTF = 1;
	localparam int WDR_RC_PWON = 0;
	localparam int WDR_RC_MSB  = 3;

	// ----------------------------------------------------------------
	// Watchdog control register fields
	// ----------------------------------------------------------------
	localparam int WDR_WC_IF   = 7;
	localparam int WDR_WC_IE   = 6;
	localparam int WDR_WC_P3   = 5;
	localparam int WDR_WC_CE   = 4;
	localparam int WDR_WC_RE   = 3;
	localparam int WDR_WC_PMSB = 2;

	// ----------------------------------------------------------------
	// Timing
	// ----------------------------------------------------------------
	localparam logic [2:0] WDR_CE_HOLD      = 3'h4;
	localparam logic [3:0] WDR_PS_MAX       = 4'h9;
	localparam int         WDR_CNT_W        = 21;
	localparam int         WDR_TIMEOUT_BASE = 2048;

endpackage

// file: core/wdr_counter.sv
// Purpose: Watchdog timeout counter clocked by oscillator ticks.
// Assumes: osc_level is the 128 kHz oscillator, synchronous to clk.
// Notes:   Timeout is a one-cycle pulse from a flip-flop.
`timescale 1ns/10ps
`default_nettype none

module wdr_counter #(
	parameter int TIMEOUT_BASE = wdr_pkg::WDR_TIMEOUT_BASE
) (
	// Clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// Control
	input  wire logic       osc_level,
	input  wire logic       run,
	input  wire logic       restart,
	input  wire logic [3:0] code,
	// Event
	output logic            timeout
);
	import wdr_pkg::*;

	typedef struct packed {
		logic [WDR_CNT_W-1:0] cnt;
		logic                 osc_prev;
		logic                 tmo;
	} wdr_cnt_t;

	localparam wdr_cnt_t WDR_CNT_RST = '0;

	wdr_cnt_t             s_q;
	wdr_cnt_t             s_d;
	logic                 tick;
	logic [3:0]           code_c;
	logic [WDR_CNT_W-1:0] limit;

	// ----------------------------------------------------------------
	// Counting
	// ----------------------------------------------------------------
	always_comb begin
		s_d = s_q;
		s_d.tmo = 1'b0;
		s_d.osc_prev = osc_level;
		// One tick per oscillator period, seen once. [R21] [R24]
		tick = osc_level & ~s_q.osc_prev;
		// Reserved codes fall back to the longest period. [R17]
		code_c = (code > WDR_PS_MAX) ? WDR_PS_MAX : code;
		limit = WDR_CNT_W'(TIMEOUT_BASE) << code_c;
		if (restart || !run) begin
			s_d.cnt = '0; // [R22]
		end else if (tick) begin
			// A shorter period may already be passed; fire at once. [R17]
			if (s_q.cnt >= limit - WDR_CNT_W'(1)) begin
				s_d.cnt = '0;
				s_d.tmo = 1'b1;
			end else begin
				s_d.cnt = s_q.cnt + WDR_CNT_W'(1);
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= WDR_CNT_RST;
		end else begin
			s_q <= s_d;
		end
	end

	assign timeout = s_q.tmo;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	restart_zero_a: assert property (@(posedge clk) disable iff (rst) // [R22]
		restart |=> s_q.cnt == '0 && !timeout)
		else $error("counter not zeroed by restart");

	cnt_bound_a: assert property (@(posedge clk) disable iff (rst) // [R17]
		run && !restart |-> s_q.cnt <= (WDR_CNT_W'(TIMEOUT_BASE) << WDR_PS_MAX))
		else $error("counter ran past longest period");

endmodule

`default_nettype wire

// file: testbench/wdr_watchdog_bench.sv
// Purpose: Self-checking bench for the watchdog and reset-cause block.
// Assumes: TIMEOUT_BASE of 4 ticks; the oscillator ticks every 4 clocks.
// Notes:   Timeout windows allow for tick phase and two cycles of latency.
`timescale 1ns/10ps
`default_nettype none

module wdr_watchdog_bench;
	import wdr_pkg::*;

	localparam int BASE = 4;
	logic       clk, rst, bus_io_space, bus_wr_en, bus_rd_en;
	logic       global_int_en, vector_ack, wdt_restart, irq_req;
	logic       ext_reset_evt, brownout_evt, always_on_fuse, osc_level;
	logic       sys_reset_pulse, osc_run;
	logic [7:0] bus_addr, bus_wdata, bus_rdata;
	logic [1:0] osc_div;
	int         failures, checks_done, resets_seen, n, r0;

	wdr_watchdog #(.TIMEOUT_BASE(BASE)) i_wdr_watchdog (
		.clk(clk), .rst(rst), .bus_addr(bus_addr),
		.bus_io_space(bus_io_space), .bus_wr_en(bus_wr_en),
		.bus_rd_en(bus_rd_en), .bus_wdata(bus_wdata), .bus_rdata(bus_rdata),
		.global_int_en(global_int_en), .vector_ack(vector_ack),
		.wdt_restart(wdt_restart), .irq_req(irq_req),
		.ext_reset_evt(ext_reset_evt), .brownout_evt(brownout_evt),
		.always_on_fuse(always_on_fuse), .osc_level(osc_level),
		.sys_reset_pulse(sys_reset_pulse)
	);

	// ------------------------------------------------------------
	// Clock, oscillator and helpers
	// ------------------------------------------------------------
	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	// The oscillator is gated so that teardown writes never race a timeout.
	always @(posedge clk) begin
		if (osc_run) begin
			osc_div <= osc_div + 2'h1;
			osc_level <= osc_div[1];
		end
		if (sys_reset_pulse === 1'b1)
			resets_seen++;
	end

	task automatic stop_test();
		$display("checks %0d failures %0d", checks_done, failures);
		if (failures == 0 && checks_done > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask

	task automatic chk(input string what, input logic [7:0] seen,
			input logic [7:0] exp);
		checks_done++;
		if (seen !== exp) begin
			failures++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic io, input logic [7:0] d);
		@(posedge clk);
		bus_addr <= a;
		bus_io_space <= io;
		bus_wdata <= d;
		bus_wr_en <= 1'b1;
		@(posedge clk);
		bus_wr_en <= 1'b0;
	endtask

	task automatic rchk(input string what, input logic [7:0] a,
			input logic io, input logic [7:0] exp);
		@(posedge clk);
		bus_addr <= a;
		bus_io_space <= io;
		bus_rd_en <= 1'b1;
		@(posedge clk);
		bus_rd_en <= 1'b0;
		#1 chk(what, bus_rdata, exp);
	endtask

	task automatic pulse(input int sel);
		@(posedge clk);
		case (sel)
			0: vector_ack <= 1'b1;
			1: wdt_restart <= 1'b1;
			2: ext_reset_evt <= 1'b1;
			default: brownout_evt <= 1'b1;
		endcase
		@(posedge clk);
		{vector_ack, wdt_restart, ext_reset_evt, brownout_evt} <= 4'h0;
	endtask

	// Waits for the reset pulse (sel 0) or the interrupt request (sel 1).
	task automatic wait_hi(input int sel, input int max, output int cnt);
		cnt = 0;
		do begin
			@(posedge clk);
			#1 cnt++;
		end while (((sel == 0) ? sys_reset_pulse : irq_req) !== 1'b1
			&& cnt < max);
		if (cnt >= max) begin
			failures++;
			$display("[ERR] wait %0d expected 1 seen 0", sel);
			stop_test();
		end
	endtask

	task automatic teardown();
		osc_run <= 1'b0;
		wr(WDR_RCAUSE_OFS, 1'b0, 8'h00);
		wr(WDR_WCTRL_OFS, 1'b0, 8'h18);
		wr(WDR_WCTRL_OFS, 1'b0, 8'h00);
		rchk("ctrl off", WDR_WCTRL_OFS, 1'b0, 8'h00);
	endtask

	// ------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------
	task automatic t_reset_values();
		rchk("cause data", WDR_RCAUSE_OFS, 1'b0, 8'h01);
		rchk("cause io", 8'h34, 1'b1, 8'h01);
		rchk("ctrl reset", 8'h60, 1'b0, 8'h00);
		rchk("unmapped", 8'h34, 1'b0, 8'h00);
		wr(8'h34, 1'b1, 8'h00);
		rchk("cause clr", 8'h54, 1'b0, 8'h00);
		$display("test reset_values done");
	endtask

	task automatic t_causes();
		pulse(3);
		rchk("brownout", 8'h54, 1'b0, 8'h04);
		pulse(2);
		rchk("external", 8'h54, 1'b0, 8'h06);
		wr(8'h54, 1'b0, 8'hFF);
		rchk("no set", 8'h54, 1'b0, 8'h06);
		wr(8'h54, 1'b0, 8'h02);
		rchk("brownout clr", 8'h54, 1'b0, 8'h02);
		wr(8'h54, 1'b0, 8'h00);
		rchk("external clr", 8'h54, 1'b0, 8'h00);
		$display("test causes done");
	endtask

	task automatic t_timed();
		wr(8'h60, 1'b0, 8'h08);
		rchk("set enable", 8'h60, 1'b0, 8'h08);
		wr(8'h60, 1'b0, 8'h01);
		rchk("locked", 8'h60, 1'b0, 8'h08);
		wr(8'h60, 1'b0, 8'h18);
		rchk("ce set", 8'h60, 1'b0, 8'h18);
		repeat (4) @(posedge clk);
		rchk("ce gone", 8'h60, 1'b0, 8'h08);
		wr(8'h60, 1'b0, 8'h00);
		rchk("late write", 8'h60, 1'b0, 8'h08);
		wr(8'h60, 1'b0, 8'h18);
		wr(8'h60, 1'b0, 8'h2A);
		rchk("new code", 8'h60, 1'b0, 8'h2A);
		wr(8'h60, 1'b0, 8'h18);
		wr(8'h60, 1'b0, 8'h00);
		rchk("disabled", 8'h60, 1'b0, 8'h00);
		$display("test timed done");
	endtask

	task automatic t_reset_mode();
		for (int c = 0; c < 3; c++) begin
			wr(8'h60, 1'b0, 8'h18);
			wr(8'h60, 1'b0, 8'h08 | 8'(c));
			pulse(1);
			osc_run <= 1'b1;
			wait_hi(0, 400, n);
			@(posedge clk);
			osc_run <= 1'b0;
			#1 chk("pulse width", {7'h00, sys_reset_pulse}, 8'h00);
			chk("period", 8'(n >= (16 << c) - 4 && n <= (16 << c) + 8), 8'h01);
			rchk("wd cause", 8'h54, 1'b0, 8'h08);
			rchk("forced", 8'h60, 1'b0, 8'h08);
			wr(8'h60, 1'b0, 8'h18);
			wr(8'h60, 1'b0, 8'h00);
			rchk("still on", 8'h60, 1'b0, 8'h08);
			teardown();
		end
		$display("test reset_mode done");
	endtask

	task automatic t_int_mode();
		r0 = resets_seen;
		wr(8'h60, 1'b0, 8'h40);
		osc_run <= 1'b1;
		repeat (40) @(posedge clk);
		#1 chk("irq gated", {7'h00, irq_req}, 8'h00);
		rchk("flag set", 8'h60, 1'b0, 8'hC0);
		global_int_en <= 1'b1;
		@(posedge clk);
		#1 chk("irq on", {7'h00, irq_req}, 8'h01);
		// Restart first so no timeout re-sets the flag before the read.
		pulse(1);
		wr(8'h60, 1'b0, 8'hC0);
		rchk("w1 clear", 8'h60, 1'b0, 8'h40);
		wait_hi(1, 200, n);
		pulse(0);
		#1 chk("irq off", {7'h00, irq_req}, 8'h00);
		rchk("ack clear", 8'h60, 1'b0, 8'h40);
		osc_run <= 1'b0;
		wr(8'h60, 1'b0, 8'h00);
		chk("no reset", 8'(resets_seen - r0), 8'h00);
		$display("test int_mode done");
	endtask

	task automatic t_combined();
		r0 = resets_seen;
		wr(8'h60, 1'b0, 8'h48);
		osc_run <= 1'b1;
		wait_hi(1, 200, n);
		pulse(0);
		rchk("to reset", 8'h60, 1'b0, 8'h08);
		chk("no reset", 8'(resets_seen - r0), 8'h00);
		// Re-enable outside the vector, then leave the interrupt unserved.
		global_int_en <= 1'b0;
		wr(8'h60, 1'b0, 8'h48);
		wait_hi(0, 400, n);
		// One period is 16 clocks; the reset comes at the second timeout.
		chk("two timeouts", 8'(n > 16 && n <= 40), 8'h01);
		teardown();
		$display("test combined done");
	endtask

	task automatic t_fuse();
		always_on_fuse <= 1'b0;
		rchk("fuse mode", 8'h60, 1'b0, 8'h08);
		wr(8'h60, 1'b0, 8'h40);
		rchk("ie locked", 8'h60, 1'b0, 8'h08);
		pulse(1);
		osc_run <= 1'b1;
		wait_hi(0, 400, n);
		chk("fuse reset", {7'h00, sys_reset_pulse}, 8'h01);
		$display("test fuse done");
	endtask

	initial begin
		{rst, bus_io_space, bus_wr_en, bus_rd_en, global_int_en} = 5'h11;
		{vector_ack, wdt_restart, ext_reset_evt, brownout_evt} = 4'h0;
		{always_on_fuse, osc_level, osc_run, osc_div} = 5'h10;
		{bus_addr, bus_wdata} = 16'h0000;
		failures = 0;
		checks_done = 0;
		resets_seen = 0;
		global_int_en = 1'b0;
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		t_reset_values();
		t_causes();
		t_timed();
		t_reset_mode();
		t_int_mode();
		t_combined();
		t_fuse();
		stop_test();
	end
endmodule

`default_nettype wire
